//--- core/flash_cmd_pkg.sv
// Purpose: Constants and types for the flash command sequencer
// Assumes: Avalon-MM byte addressing of 32-bit registers
// Notes: Offsets are byte addresses of aligned words
package flash_cmd_pkg;

  // Register byte offsets
  localparam logic [7:0] off_index = 8'h00;
  localparam logic [7:0] off_param = 8'h04;
  localparam logic [7:0] off_status = 8'h08;
  localparam logic [7:0] off_control = 8'h0c;
  localparam logic [7:0] off_security = 8'h10;

  // Status field positions
  localparam int bit_complete = 7;
  localparam int bit_access = 5;
  localparam int bit_protect = 4;
  localparam int bit_verify = 1;
  localparam int bit_uncorr = 0;

  // Control field positions
  localparam int bit_mode_ok = 0;
  localparam int bit_pflash_prot = 1;
  localparam int bit_dflash_prot = 2;
  localparam int bit_inject_err = 3;
  localparam int bit_inject_unc = 4;

  // Command codes
  localparam logic [7:0] cmd_prog_once = 8'h07;
  localparam logic [7:0] cmd_erase_all = 8'h08;
  localparam logic [7:0] cmd_erase_blk = 8'h09;
  localparam logic [7:0] cmd_erase_sec = 8'h0a;

  // Parameter slot numbers
  localparam logic [2:0] slot_cmd = 3'h0;
  localparam logic [2:0] slot_addr = 3'h1;
  localparam logic [2:0] slot_word0 = 3'h2;
  localparam logic [2:0] slot_last = 3'h5;

  // Global address field of slot 0 and block codes
  localparam logic [1:0] blk_pflash = 2'h0;
  localparam logic [1:0] blk_dflash = 2'h1;
  localparam logic [3:0] once_phrases = 4'h8;
  localparam logic [15:0] once_max_index = 16'h0007;
  localparam logic [15:0] erased_word = 16'hffff;

  // Array operation timing
  localparam int erase_time_us = 20;
  localparam int prog_time_us = 10;
  localparam int clk_mhz = 20;
  localparam int erase_cycles = erase_time_us * clk_mhz;
  localparam int prog_cycles = prog_time_us * clk_mhz;

  localparam logic [31:0] status_reset = 32'h0000_0080;

  typedef enum {
    st_idle,
    st_check,
    st_blank,
    st_program,
    st_erase,
    st_verify,
    st_done
  } seq_state_t;

  typedef struct packed {
    logic complete;
    logic access_err;
    logic protect_err;
    logic verify_err;
    logic verify_unc;
  } status_t;

endpackage

//--- core/flash_erase_program_once_cmds.sv
// Purpose: Launch checks and execution of program-once and erase commands
// Assumes: Array timing is modelled by cycle counters; one clock
// Notes: Program-once field held as an internal array of phrases
//
// How it works
// - Write-once uses code 0x07, slot 1 phrase index, slots 2-5 data.
// - Write-once launched with index pointer not 5 sets access error.
// - Phrase index above 7 sets access error.
// - Write-once checks blank, programs, verifies; completion held low.
// - An already programmed phrase is refused with access error.
// - Program flash reads are marked invalid during write-once.
// - Write-once field holds eight phrases and no erase touches it.
// - Erase-all uses code 0x08; pointer not 0 sets access error.
// - Erase-all erases both arrays, verifies, releases security if blank.
// - Any protected region makes erase-all a protection violation.
// - Verify sets error flag on any error, second flag if uncorrectable.
// - Block erase code 0x09, slot 0 block bits, slot 1 low address.
// - Block or sector erase with pointer not 1 or bad block: access error.
// - Block erase misaligned address per array sets access error.
// - Protected block makes block erase a protection violation.
// - Block erase erases and verifies whole block, then completes.
// - Sector erase code 0x0A erases and verifies the addressed sector.
// - Sector erase with address bits 2:0 nonzero sets access error.
// - Protected program flash sector makes sector erase a violation.
// - Command not allowed in current mode sets access error.
`timescale 1ns/100ps
`default_nettype none
module flash_erase_program_once_cmds
  import flash_cmd_pkg::*;
#(
  parameter int erase_wait = erase_cycles,
  parameter int prog_wait = prog_cycles
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Array status
  output logic pflash_read_invalid,
  output logic array_busy,
  output logic security_released
);

  seq_state_t state_q;
  logic [2:0] cmd_param_index_q;
  logic [15:0] cmd_param_regs_q [0:5];
  status_t status_q;
  logic [4:0] control_q;
  logic [15:0] cnt_q;
  logic [7:0] cmd_q;
  logic [15:0] once_mem_q [0:31];
  logic [7:0] once_used_q;
  logic verify_err_d;
  logic verify_unc_d;
  logic sec_q;
  logic [31:0] readdata_q;
  logic ack_q;
  logic [1:0] blk;
  logic [15:0] addr_lo;
  logic [2:0] pidx;
  logic launch;
  logic acc_err_d;
  logic prot_err_d;
  logic wr_hit;
  logic wr_index;
  logic wr_param;
  logic wr_status;
  logic wr_control;
  logic param_ok;
  logic [3:0] word_match;
  logic [3:0] word_blank;
  logic [7:0] status_byte;

  assign blk = cmd_param_regs_q[slot_cmd][1:0];
  assign addr_lo = cmd_param_regs_q[slot_addr];
  assign pidx = cmd_param_regs_q[slot_addr][2:0];
  // Writes land on the edge after the wait state, the one that ends the cycle with waitrequest low
  assign wr_hit = write && ack_q;
  assign wr_index = wr_hit && address == off_index && byteenable[0];
  assign wr_param = wr_hit && address == off_param;
  assign wr_status = wr_hit && address == off_status && byteenable[0];
  assign wr_control = wr_hit && address == off_control && byteenable[0];
  assign param_ok = cmd_param_index_q <= slot_last;
  // Launch: write 1 to clear the completion flag while idle
  assign launch = wr_status && writedata[bit_complete] && status_q.complete;

  // Read-back and blank compare of each word of the selected phrase
  for (genvar g = 0; g < 4; g++)
  begin : g_word
    assign word_match[g] = once_mem_q[{pidx, 2'(g)}]
      == cmd_param_regs_q[3'(g) + slot_word0];
    assign word_blank[g] = once_mem_q[{pidx, 2'(g)}] == erased_word;
  end

  // Status byte as software reads it
  always_comb
  begin
    status_byte = 8'h00;
    status_byte[bit_complete] = status_q.complete;
    status_byte[bit_access] = status_q.access_err;
    status_byte[bit_protect] = status_q.protect_err;
    status_byte[bit_verify] = status_q.verify_err;
    status_byte[bit_uncorr] = status_q.verify_unc;
  end

  // One wait state on every access
  assign waitrequest = (read || write) && !ack_q;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      ack_q <= 1'b0;
    else
      ack_q <= (read || write) && !ack_q;
  end

  // Launch-time checks
  always_comb
  begin
    acc_err_d = 1'b0;
    prot_err_d = 1'b0;
    if (!control_q[bit_mode_ok])
      acc_err_d = 1'b1;
    case (cmd_q)
      cmd_prog_once:
      begin
        if (cmd_param_index_q != slot_last)
          acc_err_d = 1'b1;
        if (addr_lo > once_max_index)
          acc_err_d = 1'b1;
        else if (once_used_q[pidx])
          acc_err_d = 1'b1;
      end
      cmd_erase_all:
      begin
        if (cmd_param_index_q != slot_cmd)
          acc_err_d = 1'b1;
        if (control_q[bit_pflash_prot] || control_q[bit_dflash_prot])
          prot_err_d = 1'b1;
      end
      cmd_erase_blk:
      begin
        if (cmd_param_index_q != slot_addr)
          acc_err_d = 1'b1;
        if (blk != blk_pflash && blk != blk_dflash)
          acc_err_d = 1'b1;
        if (blk == blk_pflash && addr_lo[2:0] != 3'h0)
          acc_err_d = 1'b1;
        if (blk == blk_dflash && addr_lo[0])
          acc_err_d = 1'b1;
        if ((blk == blk_pflash && control_q[bit_pflash_prot])
          || (blk == blk_dflash && control_q[bit_dflash_prot]))
          prot_err_d = 1'b1;
      end
      cmd_erase_sec:
      begin
        if (cmd_param_index_q != slot_addr)
          acc_err_d = 1'b1;
        if (blk != blk_pflash)
          acc_err_d = 1'b1;
        if (addr_lo[2:0] != 3'h0)
          acc_err_d = 1'b1;
        if (control_q[bit_pflash_prot])
          prot_err_d = 1'b1;
      end
      default:
        acc_err_d = 1'b1;
    endcase
  end

  // Verify outcome of the array step
  always_comb
  begin
    verify_err_d = control_q[bit_inject_err] || control_q[bit_inject_unc];
    verify_unc_d = control_q[bit_inject_unc];
    if (cmd_q == cmd_prog_once)
    begin
      if (word_match != 4'hf)
        verify_err_d = 1'b1;
    end
  end

  // Index pointer and parameter slots
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cmd_param_index_q <= 3'h0;
      for (int i = 0; i <= 5; i++)
        cmd_param_regs_q[i] <= 16'h0000;
    end
    else if (wr_hit && status_q.complete)
    begin
      if (wr_index)
        cmd_param_index_q <= writedata[2:0];
      // Slots above the last one are dropped
      if (wr_param && param_ok)
      begin
        if (byteenable[0])
          cmd_param_regs_q[cmd_param_index_q][7:0] <= writedata[7:0];
        if (byteenable[1])
          cmd_param_regs_q[cmd_param_index_q][15:8] <= writedata[15:8];
      end
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      control_q <= 5'h00;
    else if (wr_control && status_q.complete)
      control_q <= writedata[4:0];
  end

  // Command sequencer
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= st_idle;
      status_q.complete <= status_reset[bit_complete];
      status_q.access_err <= status_reset[bit_access];
      status_q.protect_err <= status_reset[bit_protect];
      status_q.verify_err <= status_reset[bit_verify];
      status_q.verify_unc <= status_reset[bit_uncorr];
      cnt_q <= 16'h0000;
      cmd_q <= 8'h00;
      once_used_q <= 8'h00;
      sec_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        st_idle:
        begin
          if (wr_status)
          begin
            if (writedata[bit_access])
              status_q.access_err <= 1'b0;
            if (writedata[bit_protect])
              status_q.protect_err <= 1'b0;
          end
          // A launch is ignored while the access or protection error flag is set
          if (launch && !status_q.access_err && !status_q.protect_err)
          begin
            status_q.complete <= 1'b0;
            status_q.verify_err <= 1'b0;
            status_q.verify_unc <= 1'b0;
            cmd_q <= cmd_param_regs_q[slot_cmd][15:8];
            state_q <= st_check;
          end
        end
        st_check:
        begin
          if (acc_err_d || prot_err_d)
          begin
            status_q.access_err <= acc_err_d;
            status_q.protect_err <= prot_err_d;
            state_q <= st_done;
          end
          else if (cmd_q == cmd_prog_once)
            state_q <= st_blank;
          else
          begin
            cnt_q <= 16'(erase_wait);
            state_q <= st_erase;
          end
        end
        st_blank:
        begin
          if (word_blank != 4'hf)
          begin
            status_q.access_err <= 1'b1;
            state_q <= st_done;
          end
          else
          begin
            cnt_q <= 16'(prog_wait);
            state_q <= st_program;
          end
        end
        st_program:
        begin
          cnt_q <= cnt_q - 16'h0001;
          if (cnt_q == 16'h0000)
          begin
            once_used_q[pidx] <= 1'b1;
            state_q <= st_verify;
          end
        end
        st_erase:
        begin
          cnt_q <= cnt_q - 16'h0001;
          if (cnt_q == 16'h0000)
            state_q <= st_verify;
        end
        st_verify:
        begin
          status_q.verify_err <= verify_err_d;
          status_q.verify_unc <= verify_unc_d;
          if (cmd_q == cmd_erase_all && !verify_err_d)
            sec_q <= 1'b1;
          state_q <= st_done;
        end
        st_done:
        begin
          status_q.complete <= 1'b1;
          state_q <= st_idle;
        end
        default:
          state_q <= st_idle;
      endcase
    end
  end

  // Write-once field: 8 phrases of 4 words, never erased
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < 32; i++)
        once_mem_q[i] <= erased_word;
    end
    else if (state_q == st_program && cnt_q == 16'h0000)
    begin
      for (int w = 0; w < 4; w++)
        once_mem_q[{pidx, 2'(w)}] <= cmd_param_regs_q[3'(w) + slot_word0];
    end
  end

  // Register read data
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      readdata_q <= 32'h0000_0000;
    else if (read && !ack_q)
    begin
      case (address)
        off_index:
          readdata_q <= {29'h0, cmd_param_index_q};
        off_param:
          readdata_q <= param_ok
            ? {16'h0, cmd_param_regs_q[cmd_param_index_q]} : 32'h0;
        off_status:
          readdata_q <= {24'h00_0000, status_byte};
        off_control:
          readdata_q <= {27'h0, control_q};
        off_security:
          readdata_q <= {31'h0, sec_q};
        default:
          readdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign readdata = readdata_q;
  // Busy follows the completion flag; read-invalid follows it only while the command is write-once
  assign array_busy = !status_q.complete;
  assign pflash_read_invalid = !status_q.complete
    && cmd_q == cmd_prog_once;
  assign security_released = sec_q;

endmodule // flash_erase_program_once_cmds
`default_nettype wire

//--- verif/flash_cmd_checker.sv
// Purpose: Port checker for the flash command sequencer
// Assumes: Bound to the top module; one clock domain
// Notes: Busy length bound follows the wait parameters
`timescale 1ns/100ps
`default_nettype none
module flash_cmd_checker
  import flash_cmd_pkg::*;
#(
  parameter int erase_wait = erase_cycles,
  parameter int prog_wait = prog_cycles
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Bus
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // Status
  input wire logic pflash_read_invalid,
  input wire logic array_busy,
  input wire logic security_released
);
  logic [15:0] busy_q;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Length of the current busy stretch
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      busy_q <= 16'h0000;
    else
      busy_q <= array_busy ? busy_q + 16'h0001 : 16'h0000;
  end
  a_wait_first: assert property ((read || write) && !$past(read || write)
    |-> waitrequest ##1 !waitrequest) else $error("bad wait cycle");
  a_rdata_hold: assert property ($changed(readdata) |-> $past(read))
    else $error("readdata moved without read");
  a_launch_cause: assert property ($rose(array_busy) |->
    $past(write) && $past(address) == off_status
    && $past(writedata[bit_complete])) else $error("busy without launch");
  a_busy_min: assert property ($rose(array_busy) |->
    array_busy [*2]) else $error("busy too short");
  a_busy_bound: assert property (
    busy_q <= 16'(2 * (erase_wait + prog_wait) + 20))
    else $error("busy too long");
  a_invalid_busy: assert property (
    pflash_read_invalid |-> array_busy) else $error("invalid while idle");
  a_secure_sticky: assert property (
    security_released |=> security_released) else $error("security lost");
  a_secure_after: assert property ($rose(security_released) |->
    $past(array_busy)) else $error("security released while idle");
endmodule // flash_cmd_checker
bind flash_erase_program_once_cmds flash_cmd_checker #(
  .erase_wait(erase_wait),
  .prog_wait(prog_wait)
) u_flash_cmd_checker (
  .mclk(mclk),
  .rst(rst),
  .address(address),
  .read(read),
  .write(write),
  .writedata(writedata),
  .readdata(readdata),
  .waitrequest(waitrequest),
  .pflash_read_invalid(pflash_read_invalid),
  .array_busy(array_busy),
  .security_released(security_released)
);
`default_nettype wire

//--- verif/flash_erase_program_once_cmds_bench.sv
// Purpose: Self-checking bench for the flash command sequencer
// Assumes: Short wait parameters; bus sampled at the rising edge
// Notes: Access and protection error flags are cleared after every command
`timescale 1ns/100ps
`default_nettype none
module flash_erase_program_once_cmds_bench
  import flash_cmd_pkg::*;
;
  logic mclk, rst, read, write, waitrequest;
  logic pflash_read_invalid, array_busy, security_released;
  logic [7:0] address;
  logic [31:0] writedata, readdata, q;
  int n_errors, checks;
  flash_erase_program_once_cmds #(
    .erase_wait(4),
    .prog_wait(2)
  ) u_flash_erase_program_once_cmds (
    .mclk(mclk),
    .rst(rst),
    .address(address),
    .read(read),
    .write(write),
    .writedata(writedata),
    .byteenable(4'hf),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .pflash_read_invalid(pflash_read_invalid),
    .array_busy(array_busy),
    .security_released(security_released)
  );
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic stop_test();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic hang();
    n_errors++;
    $display("[FAIL] %0t wait ran out", $time);
    stop_test();
  endtask
  // One bus cycle, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    @(posedge mclk);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 20);
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    if (n >= 20)
      hang();
  endtask
  // Load slots 0..last, launch, wait, compare status, clear errors
  task automatic cmd(input logic [7:0] c, input logic [1:0] b,
    input logic [15:0] a, input int last, input logic [7:0] exp);
    int n;
    logic seen;
    bus(1'b1, off_index, 32'h0000_0000);
    bus(1'b1, off_param, {16'h0000, c, 6'h00, b});
    for (int i = 1; i <= last; i++)
    begin
      bus(1'b1, off_index, 32'(i));
      bus(1'b1, off_param, {16'h0000, (i == 1) ? a : 16'h1234});
    end
    bus(1'b1, off_status, 32'h0000_0080);
    @(negedge mclk);
    check({31'h0000_0000, array_busy}, 32'h0000_0001);
    n = 0;
    seen = 1'b0;
    while (array_busy !== 1'b0 && n < 200)
    begin
      seen = seen | pflash_read_invalid;
      @(negedge mclk);
      n++;
    end
    if (n >= 200)
      hang();
    if (exp == 8'h80)
      check({31'h0000_0000, seen}, {31'h0000_0000, c == cmd_prog_once});
    bus(1'b0, off_status, 32'h0000_0000);
    check(q & 32'h0000_00b3, {24'h00_0000, exp});
    bus(1'b1, off_status, 32'h0000_0030);
  endtask
  task automatic t_launch();
    bus(1'b0, off_security, 32'h0000_0000);
    check(q, 32'h0000_0000);
    cmd(cmd_erase_all, 2'h0, 16'h0000, 0, 8'ha0);
    bus(1'b1, off_control, 32'h0000_0001);
    cmd(cmd_erase_all, 2'h0, 16'h0000, 1, 8'ha0);
    cmd(cmd_prog_once, 2'h0, 16'h0003, 4, 8'ha0);
    cmd(cmd_erase_blk, 2'h1, 16'h0002, 0, 8'ha0);
    cmd(cmd_erase_sec, 2'h0, 16'h0008, 2, 8'ha0);
    $display("launch checks done");
  endtask
  task automatic t_once();
    cmd(cmd_prog_once, 2'h0, 16'h0008, 5, 8'ha0);
    cmd(cmd_prog_once, 2'h0, 16'h0000, 5, 8'h80);
    cmd(cmd_prog_once, 2'h0, 16'h0007, 5, 8'h80);
    cmd(cmd_prog_once, 2'h0, 16'h0007, 5, 8'ha0);
    $display("write-once done");
  endtask
  task automatic t_erase();
    cmd(cmd_erase_blk, 2'h2, 16'h0000, 1, 8'ha0);
    cmd(cmd_erase_blk, 2'h0, 16'h0004, 1, 8'ha0);
    cmd(cmd_erase_blk, 2'h1, 16'h0001, 1, 8'ha0);
    cmd(cmd_erase_blk, 2'h1, 16'h0002, 1, 8'h80);
    cmd(cmd_erase_blk, 2'h0, 16'h0000, 1, 8'h80);
    cmd(cmd_erase_sec, 2'h0, 16'h0003, 1, 8'ha0);
    cmd(cmd_erase_sec, 2'h2, 16'h0000, 1, 8'ha0);
    cmd(cmd_erase_sec, 2'h0, 16'h0108, 1, 8'h80);
    bus(1'b1, off_control, 32'h0000_0003);
    cmd(cmd_erase_blk, 2'h0, 16'h0000, 1, 8'h90);
    cmd(cmd_erase_sec, 2'h0, 16'h0008, 1, 8'h90);
    $display("block and sector done");
  endtask
  task automatic t_all();
    bus(1'b1, off_control, 32'h0000_0009);
    cmd(cmd_erase_sec, 2'h0, 16'h0010, 1, 8'h82);
    bus(1'b1, off_control, 32'h0000_0019);
    cmd(cmd_erase_blk, 2'h1, 16'h0000, 1, 8'h83);
    bus(1'b1, off_control, 32'h0000_0009);
    cmd(cmd_erase_all, 2'h0, 16'h0000, 0, 8'h82);
    check({31'h0000_0000, security_released}, 32'h0000_0000);
    bus(1'b1, off_control, 32'h0000_0005);
    cmd(cmd_erase_all, 2'h0, 16'h0000, 0, 8'h90);
    bus(1'b1, off_control, 32'h0000_0001);
    cmd(cmd_erase_all, 2'h0, 16'h0000, 0, 8'h80);
    bus(1'b0, off_security, 32'h0000_0000);
    check(q & 32'h0000_0001, 32'h0000_0001);
    cmd(cmd_prog_once, 2'h0, 16'h0007, 5, 8'ha0);
    bus(1'b0, 8'h20, 32'h0000_0000);
    check(q, 32'h0000_0000);
    $display("erase-all done");
  endtask
  initial
  begin
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 8'h00;
    writedata = 32'h0000_0000;
    n_errors = 0;
    checks = 0;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    t_launch();
    t_once();
    t_erase();
    t_all();
    stop_test();
  end
endmodule // flash_erase_program_once_cmds_bench
`default_nettype wire
